// ===== rtl/scw_spi_cfg_wake.sv
// Serial port configuration, interrupt and request logic and wake-up from halt
`timescale 1ns/100ps
module scw_spi_cfg_wake (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Register port
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Power state
  input wire logic i_halt,
  input wire logic i_wait,
  // Pins
  input wire logic i_sck,
  input wire logic i_slave_select_pin_n,
  output logic o_sck,
  output logic o_sck_oe,
  // Datapath state
  input wire logic i_frame_active,
  input wire logic i_busy,
  input wire logic i_tx_buffer_empty,
  input wire logic i_rx_buffer_full,
  input wire logic i_role_fault,
  input wire logic i_receive_overrun,
  input wire logic i_check_mismatch,
  // Configuration to datapath
  output logic o_low_bit_first,
  output logic o_port_enable,
  output logic o_master_select,
  output logic o_clock_idle_level,
  output logic o_capture_edge_select,
  output logic o_one_line_mode,
  output logic o_one_line_output_dir,
  output logic o_check_calc_enable,
  output logic o_send_check_next,
  output logic o_receive_only,
  output logic o_slave_selected,
  output logic o_port_active,
  output logic o_master_edge,
  // Requests
  output logic o_irq,
  output logic o_wait_exit,
  output logic o_halt_wake,
  output logic o_tx_dma_req,
  output logic o_rx_dma_req
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] frame_clock_control;
  logic [7:0] line_crc_select_control;
  logic [7:0] irq_dma_enable;
  logic wake_flag;

  wire reg_wr = i_wr && !i_halt;
  wire wr_frame = reg_wr && (i_addr == scw_pkg::ADDR_FRAME);
  wire wr_line = reg_wr && (i_addr == scw_pkg::ADDR_LINE);
  wire wr_irq = reg_wr && (i_addr == scw_pkg::ADDR_IRQ);
  wire wr_status = reg_wr && (i_addr == scw_pkg::ADDR_STATUS);

  // Frozen while halted
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      frame_clock_control <= scw_pkg::RST_FRAME;
      line_crc_select_control <= scw_pkg::RST_LINE;
      irq_dma_enable <= scw_pkg::RST_IRQ;
    end else begin
      if (wr_frame) begin
        frame_clock_control <= i_wdata;
      end
      if (wr_line) begin
        line_crc_select_control <= i_wdata;
      end
      if (wr_irq) begin
        irq_dma_enable <= i_wdata & scw_pkg::IRQ_MASK;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Field decode

  wire low_bit_first = frame_clock_control[scw_pkg::F_LOW_FIRST];
  wire port_enable = frame_clock_control[scw_pkg::F_ENABLE];
  wire [2:0] baud_divider = frame_clock_control[scw_pkg::F_BAUD_HI:scw_pkg::F_BAUD_LO];
  wire master_select = frame_clock_control[scw_pkg::F_MASTER];
  wire clock_idle_level = frame_clock_control[scw_pkg::F_IDLE];
  wire capture_edge_select = frame_clock_control[scw_pkg::F_CAPTURE];
  wire one_line_mode = line_crc_select_control[scw_pkg::L_ONE_LINE];
  wire one_line_output_dir = line_crc_select_control[scw_pkg::L_OUT_DIR];
  wire check_calc_enable = line_crc_select_control[scw_pkg::L_CHECK_EN];
  wire send_check_next = line_crc_select_control[scw_pkg::L_CHECK_NEXT];
  wire receive_only = line_crc_select_control[scw_pkg::L_RX_ONLY];
  wire soft_select_manage = line_crc_select_control[scw_pkg::L_SOFT_MANAGE];
  wire soft_select_level = line_crc_select_control[scw_pkg::L_SOFT_LEVEL];
  wire tx_empty_irq_en = irq_dma_enable[scw_pkg::I_TX_IRQ];
  wire rx_full_irq_en = irq_dma_enable[scw_pkg::I_RX_IRQ];
  wire fault_irq_en = irq_dma_enable[scw_pkg::I_FAULT_IRQ];
  wire wake_irq_en = irq_dma_enable[scw_pkg::I_WAKE_IRQ];
  wire tx_dma_req_en = irq_dma_enable[scw_pkg::I_TX_DMA];
  wire rx_dma_req_en = irq_dma_enable[scw_pkg::I_RX_DMA];

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic sck_meta;
  logic sck_sync;
  logic sck_prev;
  logic sel_meta;
  logic sel_sync_n;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sck_meta <= 1'b0;
      sck_sync <= 1'b0;
      sck_prev <= 1'b0;
      sel_meta <= 1'b1;
      sel_sync_n <= 1'b1;
    end else begin
      sck_meta <= i_sck;
      sck_sync <= sck_meta;
      sck_prev <= sck_sync;
      sel_meta <= i_slave_select_pin_n;
      sel_sync_n <= sel_meta;
    end
  end

  // Select pin replaced by the soft level when managed in software
  wire select_n = soft_select_manage ? soft_select_level : sel_sync_n;

  ////////////////////////////////////////////////////////////////////////////
  // Wake-up detection

  // Leading edge leaves the idle level, trailing edge returns to it
  wire lead_edge = (sck_prev == clock_idle_level) && (sck_sync != clock_idle_level);
  wire trail_edge = (sck_prev != clock_idle_level) && (sck_sync == clock_idle_level);
  wire sample_edge = capture_edge_select ? trail_edge : lead_edge;
  // A selected slave keeps listening in halt
  // Receive-only setups are not blocked; wake-up is only not promised there
  wire halt_slave = i_halt && port_enable && !master_select && !select_n;
  wire wake_set = halt_slave && sample_edge;
  wire wake_clr = wr_status && !i_wdata[scw_pkg::S_WAKE];

  // Set wins over a clear in the same cycle; only software clears
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wake_flag <= 1'b0;
    end else if (wake_set) begin
      wake_flag <= 1'b1;
    end else if (wake_clr) begin
      wake_flag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master serial clock

  // Port runs while enabled and not halted; in halt only as a selected slave
  wire port_active = port_enable && !i_halt;
  wire master_run = port_active && master_select && i_frame_active;
  logic [scw_pkg::DIV_W-1:0] div_cnt;
  logic sck_drive;
  // Half period is two to the baud field, so a full period is twice that
  wire [scw_pkg::DIV_W-1:0] half_last = (scw_pkg::DIV_W)'((9'h001 << baud_divider) - 9'h001);
  wire half_done = (div_cnt == half_last);
  wire [scw_pkg::DIV_W-1:0] next_div_cnt =
    (!master_run || half_done) ? '0 : div_cnt + 8'h01;
  wire next_sck_drive =
    !master_run ? clock_idle_level : (half_done ? !sck_drive : sck_drive);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      div_cnt <= '0;
      sck_drive <= 1'b0;
      o_master_edge <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      sck_drive <= next_sck_drive;
      o_master_edge <= master_run && half_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Requests

  // Buffer and error events may end wait; only the wake event ends halt
  wire irq_tx = tx_empty_irq_en && i_tx_buffer_empty;
  wire irq_rx = rx_full_irq_en && i_rx_buffer_full;
  wire irq_err = fault_irq_en &&
    (i_check_mismatch || i_receive_overrun || i_role_fault);
  wire irq_wake = wake_irq_en && wake_flag;
  wire next_irq = irq_tx || irq_rx || irq_err || irq_wake;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_irq <= 1'b0;
      o_wait_exit <= 1'b0;
      o_halt_wake <= 1'b0;
      o_tx_dma_req <= 1'b0;
      o_rx_dma_req <= 1'b0;
    end else begin
      o_irq <= next_irq;
      o_wait_exit <= i_wait && next_irq;
      o_halt_wake <= irq_wake;
      o_tx_dma_req <= tx_dma_req_en && i_tx_buffer_empty;
      o_rx_dma_req <= rx_dma_req_en && i_rx_buffer_full;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration outputs

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_low_bit_first <= 1'b0;
      o_port_enable <= 1'b0;
      o_master_select <= 1'b0;
      o_clock_idle_level <= 1'b0;
      o_capture_edge_select <= 1'b0;
      o_one_line_mode <= 1'b0;
      o_one_line_output_dir <= 1'b0;
      o_check_calc_enable <= 1'b0;
      o_send_check_next <= 1'b0;
      o_receive_only <= 1'b0;
      o_slave_selected <= 1'b0;
      o_port_active <= 1'b0;
      o_sck <= 1'b0;
      o_sck_oe <= 1'b0;
    end else begin
      o_low_bit_first <= low_bit_first;
      o_port_enable <= port_enable;
      o_master_select <= master_select;
      o_clock_idle_level <= clock_idle_level;
      o_capture_edge_select <= capture_edge_select;
      o_one_line_mode <= one_line_mode;
      o_one_line_output_dir <= one_line_output_dir;
      o_check_calc_enable <= check_calc_enable;
      o_send_check_next <= send_check_next;
      o_receive_only <= receive_only;
      o_slave_selected <= !select_n;
      o_port_active <= port_active || halt_slave;
      o_sck <= sck_drive;
      o_sck_oe <= port_enable && master_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read port

  wire [7:0] status_view = {
    i_busy, i_receive_overrun, i_role_fault, i_check_mismatch,
    wake_flag, 1'b0, i_tx_buffer_empty, i_rx_buffer_full
  };
  wire [7:0] next_rdata =
    !i_rd ? 8'h00 :
    (i_addr == scw_pkg::ADDR_FRAME) ? frame_clock_control :
    (i_addr == scw_pkg::ADDR_LINE) ? line_crc_select_control :
    (i_addr == scw_pkg::ADDR_IRQ) ? irq_dma_enable :
    (i_addr == scw_pkg::ADDR_STATUS) ? status_view : 8'h00;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  AST_TX_DMA: assert property (
    tx_dma_req_en && i_tx_buffer_empty |=> o_tx_dma_req)
    else $error("transmit request missing");

  AST_RX_DMA_OFF: assert property (
    !(rx_dma_req_en && i_rx_buffer_full) |=> !o_rx_dma_req)
    else $error("receive request without cause");

  AST_IRQ_MASKED: assert property (
    !tx_empty_irq_en && !rx_full_irq_en && !fault_irq_en && !wake_irq_en
    |=> !o_irq)
    else $error("interrupt raised while all masked");

  AST_ERR_IRQ: assert property (
    fault_irq_en && $rose(i_receive_overrun) |=> o_irq)
    else $error("error interrupt missing");

  AST_WAKE_SET: assert property (
    i_halt && port_enable && !master_select && !select_n && sample_edge
    |=> wake_flag)
    else $error("wake flag not set on sampling edge");

  AST_WAKE_HOLD: assert property (
    wake_flag && !wake_clr |=> wake_flag)
    else $error("wake flag cleared without software");

  AST_HALT_WAKE: assert property (
    wake_flag && wake_irq_en |=> o_halt_wake)
    else $error("halt wake-up request missing");

  AST_HALT_ONLY_WAKE: assert property (
    o_halt_wake |-> $past(wake_flag) && $past(wake_irq_en))
    else $error("halt ended by another event");

  AST_FROZEN: assert property (
    i_halt && i_wr |=> $stable(frame_clock_control) && $stable(irq_dma_enable))
    else $error("register changed in halt");

  AST_SCK_IDLE: assert property (
    !master_run [*2] |=> o_sck == $past(clock_idle_level, 2))
    else $error("serial clock not at idle level");

  AST_WAIT_EXIT: assert property (
    i_wait && wake_flag && wake_irq_en |=> o_wait_exit)
    else $error("wait not ended by enabled event");

  COV_WAKE: cover property (halt_slave ##1 wake_flag ##1 o_halt_wake);
  COV_DMA: cover property (o_tx_dma_req ##1 o_rx_dma_req);
  COV_MASTER: cover property (master_run ##1 o_master_edge);

endmodule

// ===== rtl/scw_pkg.sv
// Register map, field positions and reset values of the serial port control block
package scw_pkg;
  // Register addresses
  localparam logic [2:0] ADDR_FRAME = 3'h0;
  localparam logic [2:0] ADDR_LINE = 3'h1;
  localparam logic [2:0] ADDR_IRQ = 3'h2;
  localparam logic [2:0] ADDR_STATUS = 3'h3;
  // Reset values
  localparam logic [7:0] RST_FRAME = 8'h00;
  localparam logic [7:0] RST_LINE = 8'h00;
  localparam logic [7:0] RST_IRQ = 8'h00;
  // Writable bits of the interrupt and request enable register
  localparam logic [7:0] IRQ_MASK = 8'hf3;
  // Frame and clock control fields
  localparam int F_LOW_FIRST = 7;
  localparam int F_ENABLE = 6;
  localparam int F_BAUD_HI = 5;
  localparam int F_BAUD_LO = 3;
  localparam int F_MASTER = 2;
  localparam int F_IDLE = 1;
  localparam int F_CAPTURE = 0;
  // Line, check and select control fields
  localparam int L_ONE_LINE = 7;
  localparam int L_OUT_DIR = 6;
  localparam int L_CHECK_EN = 5;
  localparam int L_CHECK_NEXT = 4;
  localparam int L_RX_ONLY = 2;
  localparam int L_SOFT_MANAGE = 1;
  localparam int L_SOFT_LEVEL = 0;
  // Interrupt and request enable fields
  localparam int I_TX_IRQ = 7;
  localparam int I_RX_IRQ = 6;
  localparam int I_FAULT_IRQ = 5;
  localparam int I_WAKE_IRQ = 4;
  localparam int I_TX_DMA = 1;
  localparam int I_RX_DMA = 0;
  // Status fields
  localparam int S_BUSY = 7;
  localparam int S_OVERRUN = 6;
  localparam int S_ROLE_FAULT = 5;
  localparam int S_MISMATCH = 4;
  localparam int S_WAKE = 3;
  localparam int S_TX_EMPTY = 1;
  localparam int S_RX_FULL = 0;
  // Baud divider counter width
  localparam int DIV_W = 8;
endpackage

// ===== sim/scw_ext_master.sv
// Behavioural external serial master driving the clock and select pins
`timescale 1ns/100ps
module scw_ext_master (
  input wire logic i_go,
  input wire logic i_idle,
  output logic o_sck,
  output logic o_select_n,
  output logic o_busy
);
  initial begin
    o_select_n = 1'b1;
    o_busy = 1'b0;
    o_sck = 1'b0;
  end
  // Clock stands at its idle level between frames
  always @(i_idle) if (!o_busy) o_sck = i_idle;
  // One frame of clock and select only, eight bits of two edges each
  always @(posedge i_go) begin
    o_busy = 1'b1;
    o_select_n = 1'b0;
    #137;
    repeat (16) begin
      o_sck = ~o_sck;
      #100;
    end
    o_select_n = 1'b1;
    o_busy = 1'b0;
  end
endmodule

// ===== sim/spi_config_irq_wakeup_tb.sv
// Self-checking bench of the serial port control and wake-up block
`timescale 1ns/100ps
module spi_config_irq_wakeup_tb;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_halt = 1'b0;
  logic i_wait = 1'b0;
  logic i_frame_active = 1'b0;
  logic i_busy = 1'b0;
  logic i_tx_buffer_empty = 1'b1;
  logic i_rx_buffer_full = 1'b0;
  logic i_role_fault = 1'b0;
  logic i_receive_overrun = 1'b0;
  logic i_check_mismatch = 1'b0;
  logic go = 1'b0;
  logic pidle = 1'b0;
  logic sck, sel_n, pbusy;
  logic [7:0] o_rdata, f, l, e, d;
  logic o_sck, o_sck_oe, o_low_bit_first, o_port_enable, o_master_select;
  logic o_clock_idle_level, o_capture_edge_select, o_one_line_mode, o_one_line_output_dir;
  logic o_check_calc_enable, o_send_check_next, o_receive_only, o_slave_selected;
  logic o_port_active, o_master_edge, o_irq, o_wait_exit, o_halt_wake;
  logic o_tx_dma_req, o_rx_dma_req;
  int seed = 32'hb66cf94d;
  int n_fail = 0;
  int n_compared = 0;
  int k, n;

  initial forever #12.5 i_clk = ~i_clk;

  scw_ext_master scw_ext_master_inst (.i_go(go), .i_idle(pidle), .o_sck(sck),
    .o_select_n(sel_n), .o_busy(pbusy));

  scw_spi_cfg_wake scw_spi_cfg_wake_inst (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .i_halt(i_halt),
    .i_wait(i_wait),
    .i_sck(sck),
    .i_slave_select_pin_n(sel_n),
    .o_sck(o_sck),
    .o_sck_oe(o_sck_oe),
    .i_frame_active(i_frame_active),
    .i_busy(i_busy),
    .i_tx_buffer_empty(i_tx_buffer_empty),
    .i_rx_buffer_full(i_rx_buffer_full),
    .i_role_fault(i_role_fault),
    .i_receive_overrun(i_receive_overrun),
    .i_check_mismatch(i_check_mismatch),
    .o_low_bit_first(o_low_bit_first),
    .o_port_enable(o_port_enable),
    .o_master_select(o_master_select),
    .o_clock_idle_level(o_clock_idle_level),
    .o_capture_edge_select(o_capture_edge_select),
    .o_one_line_mode(o_one_line_mode),
    .o_one_line_output_dir(o_one_line_output_dir),
    .o_check_calc_enable(o_check_calc_enable),
    .o_send_check_next(o_send_check_next),
    .o_receive_only(o_receive_only),
    .o_slave_selected(o_slave_selected),
    .o_port_active(o_port_active),
    .o_master_edge(o_master_edge),
    .o_irq(o_irq),
    .o_wait_exit(o_wait_exit),
    .o_halt_wake(o_halt_wake),
    .o_tx_dma_req(o_tx_dma_req),
    .o_rx_dma_req(o_rx_dma_req)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
  endtask

  function automatic logic [3:0] exp_req(input logic [7:0] en, input logic w);
    logic irq;
    irq = (en[7] & i_tx_buffer_empty) | (en[6] & i_rx_buffer_full) |
      (en[5] & (i_role_fault | i_receive_overrun | i_check_mismatch));
    return {irq, w & irq, en[1] & i_tx_buffer_empty, en[0] & i_rx_buffer_full};
  endfunction

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #(25 * 100000);
    n_fail++;
    test_done();
  end

  initial begin
    repeat (8) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    for (int a = 0; a < 4; a++) begin
      rd(a[2:0], d);
      chk(d, (a == 3) ? 8'h02 : 8'h00);
    end
    // Register access, configuration outputs and request gating
    repeat (40) begin
      f = 8'($random(seed));
      l = 8'($random(seed));
      e = 8'($random(seed));
      if (e[7]) e[1] = 1'b0;
      if (e[6]) e[0] = 1'b0;
      wr(3'h0, f);
      wr(3'h1, l);
      wr(3'h2, e);
      rd(3'h0, d);
      chk(d, f);
      rd(3'h1, d);
      chk(d, l);
      rd(3'h2, d);
      chk(d, e & 8'hf3);
      rd(3'h5, d);
      chk(d, 8'h00);
      chk({o_low_bit_first, o_port_enable, o_master_select, o_clock_idle_level,
        o_capture_edge_select, o_port_active, 2'h0}, {f[7], f[6], f[2:0], f[6], 2'h0});
      chk({o_one_line_mode, o_one_line_output_dir, o_check_calc_enable, o_send_check_next,
        o_receive_only, 3'h0}, {l[7:4], l[2], 3'h0});
      chk({7'h0, o_slave_selected}, {7'h0, l[1] & ~l[0]});
      @(posedge i_clk);
      {i_busy, i_receive_overrun, i_role_fault, i_check_mismatch, i_tx_buffer_empty,
        i_rx_buffer_full, i_wait} <= 7'($random(seed));
      repeat (3) @(posedge i_clk);
      #1;
      chk({4'h0, o_irq, o_wait_exit, o_tx_dma_req, o_rx_dma_req},
        {4'h0, exp_req(e, i_wait)});
    end
    // Wake-up from halt as a slave, selected and not selected
    @(posedge i_clk);
    {i_busy, i_receive_overrun, i_role_fault, i_check_mismatch, i_rx_buffer_full} <= 5'h00;
    i_wait <= 1'b0;
    i_tx_buffer_empty <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      f = 8'h40 | (8'($random(seed)) & 8'h03);
      pidle = f[1];
      wr(3'h0, f);
      wr(3'h1, {7'h01, s[0]});
      wr(3'h2, 8'h90);
      @(posedge i_clk);
      i_halt <= 1'b1;
      repeat (4) @(posedge i_clk);
      #1;
      chk({6'h0, o_irq, o_halt_wake}, 8'h02);
      chk({7'h0, o_port_active}, {7'h0, s == 0});
      @(posedge i_clk);
      go <= 1'b1;
      @(posedge i_clk);
      go <= 1'b0;
      for (k = 0; k < 200 && o_halt_wake !== 1'b1; k++) @(posedge i_clk);
      while (pbusy) @(posedge i_clk);
      #1;
      chk({7'h0, o_halt_wake}, {7'h0, s == 0});
      @(posedge i_clk);
      i_halt <= 1'b0;
      rd(3'h3, d);
      chk(d, {4'h0, s == 0, 3'h2});
      wr(3'h3, 8'h00);
      rd(3'h3, d);
      chk(d, 8'h02);
    end
    // Master clock rate, idle level and stop in halt
    for (int b = 0; b < 8; b++) begin
      f = {2'b01, b[2:0], 2'b10, 1'($random(seed))};
      f[1] = 1'($random(seed));
      wr(3'h0, f);
      @(posedge i_clk);
      i_frame_active <= 1'b1;
      k = 0;
      while (o_master_edge !== 1'b1 && k < 600) begin
        @(posedge i_clk);
        #1;
        k++;
      end
      k = 0;
      do begin
        @(posedge i_clk);
        #1;
        k++;
      end while (o_master_edge !== 1'b1 && k < 600);
      chk(8'(k), 8'(1 << b));
      chk({6'h0, o_sck_oe, o_master_select}, 8'h03);
      @(posedge i_clk);
      i_halt <= 1'b1;
      repeat (300) @(posedge i_clk);
      n = 0;
      repeat (300) begin
        @(posedge i_clk);
        #1;
        n += int'(o_master_edge);
      end
      chk(8'(n), 8'h00);
      chk({7'h0, o_sck}, {7'h0, f[1]});
      @(posedge i_clk);
      i_halt <= 1'b0;
      i_frame_active <= 1'b0;
    end
    test_done();
  end
endmodule
